// ==== tb_top.sv ====
// Self-checking bench for the timer I/O and mode configuration block
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("wrong value %s expected %0h seen %0h", n, e, g); \
    end \
  end
module tb_top;
  localparam logic [31:0] PIO = tio_pkg::ADDR_PIN_IO;
  localparam logic [31:0] MOD = tio_pkg::ADDR_MODE;
  localparam logic [31:0] PRE = tio_pkg::ADDR_PRESC;
  localparam logic [1:0]  OK  = tio_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = tio_pkg::RESP_SLVERR;
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, mode;
  logic        trigCmd = 1'b0, ufOn = 1'b0, cntSt = 1'b0;
  logic        inPrim = 1'b0, pulseOn = 1'b0;
  logic        extPin, raUf, wrc, srcTick, pLoad, fire, wPin, wEn, loadLvl;
  logic [7:0]  pVal;
  int          mismatches = 0, comparisons = 0, ticks = 0, fires = 0;
  int          loads = 0, n;
  logic [6:0]  wv[15] = '{7'h2D, 7'h28, 7'h20, 7'h3C, 7'h39, 7'h31, 7'h43,
    7'h40, 7'h52, 7'h51, 7'h63, 7'h60, 7'h72, 7'h71, 7'h00};
  logic [10:0] tc[11] = '{11'h065, 11'h044, 11'h025, 11'h067, 11'h062,
    11'h0E4, 11'h0E5, 11'h164, 11'h165, 11'h1E4, 11'h1E5};
  int          tw[11] = '{20, 20, 20, 20, 20, 2, 20, 12, 80, 48, 300};
  int          ts[9] = '{256, 32, 64, 128, 64, 8, 4, 2, 0};

  always #2 clk = ~clk;

  tio_timer_cfg i_tio_timer_cfg (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .extTriggerPin(extPin),
    .raUnderflow(raUf), .countingStatus(cntSt), .inPrimary(inPrim),
    .pulseOn(pulseOn), .opModeSel(mode), .reloadWriteCtrl(wrc),
    .countSrcTick(srcTick), .prescReloadVal(pVal), .prescCntLoad(pLoad),
    .trigFire(fire), .waveOutPin(wPin), .waveOutPinEn(wEn));

  tio_far_model i_tio_far_model (.clk(clk), .trigCmd(trigCmd), .ufOn(ufOn),
    .outPin(wPin), .outEn(wEn), .trigPin(extPin), .ufPulse(raUf),
    .loadLvl(loadLvl));

  // Pulse counters sample away from the driving edge
  always @(negedge clk)
  begin
    if (srcTick === 1'b1) ticks++;
    if (fire === 1'b1) fires++;
    if (pLoad === 1'b1) loads++;
  end

  // ****************************
  // Bus tasks and closing
  // ****************************
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (awvalid || wvalid);
    do @(posedge clk); while (bvalid !== 1'b1);
    `CHK("bresp", er, bresp)
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
    rready <= 1'b0;
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    mismatches++;
    results;
  end

  // ****************************
  // Test sequence
  // ****************************
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(PIO, 32'h0, OK);
    rd(MOD, 32'h0, OK);
    rd(PRE, 32'hFF, OK);
    wr(PIO, 8'hFF, OK);
    rd(PIO, 32'h3F, OK);
    wr(MOD, 8'hFF, OK);
    rd(MOD, 32'hFB, OK);
    wr(32'h0, 8'h01, ERR);
    rd(32'h0, 32'h0, ERR);
    foreach (wv[i])
    begin
      cntSt <= 1'b0;
      wr(MOD, {6'h2, wv[i][6:5]}, OK);
      wr(PIO, {7'h0, wv[i][4]}, OK);
      cntSt <= wv[i][3];
      inPrim <= wv[i][2];
      pulseOn <= wv[i][1];
      repeat (4) @(posedge clk);
      `CHK("mode", wv[i][6:5], mode)
      `CHK("level", wv[i][0], loadLvl)
      `CHK("enable", 1'b1, wEn)
    end
    wr(PIO, 8'h03, OK);
    repeat (2) @(posedge clk);
    `CHK("enable", 1'b0, wEn)
    `CHK("pin", 1'b0, wPin)
    foreach (tw[i])
    begin
      wr(MOD, {6'h2, tc[i][2:1]}, OK);
      wr(PIO, tc[i][10:3], OK);
      n = fires;
      trigCmd <= 1'b1;
      repeat (tw[i]) @(posedge clk);
      trigCmd <= 1'b0;
      repeat (350) @(posedge clk);
      `CHK("fires", 32'(tc[i][0]), fires - n)
    end
    wr(PIO, 8'h00, OK);
    ufOn <= 1'b1;
    for (int s = 0; s < 9; s++)
    begin
      wr(MOD, s < 8 ? {1'b0, 3'(s), 4'h8} : 8'h88, OK);
      repeat (4) @(posedge clk);
      n = ticks;
      repeat (256) @(posedge clk);
      `CHK("ticks", ts[s], ticks - n)
    end
    wr(MOD, 8'h00, OK);
    n = loads;
    wr(PRE, 8'h5A, OK);
    repeat (3) @(posedge clk);
    `CHK("loads", 1, loads - n)
    rd(PRE, 32'h5A, OK);
    wr(MOD, 8'h70, OK);
    `CHK("wrc", 1'b0, wrc)
    cntSt <= 1'b1;
    n = loads;
    wr(PRE, 8'h33, OK);
    repeat (300) @(posedge clk);
    `CHK("loads", 1, loads - n)
    cntSt <= 1'b0;
    wr(MOD, 8'h78, OK);
    `CHK("wrc", 1'b1, wrc)
    cntSt <= 1'b1;
    n = loads;
    wr(PRE, 8'h44, OK);
    repeat (300) @(posedge clk);
    `CHK("loads", 0, loads - n)
    `CHK("reload", 8'h44, pVal)
    rd(tio_pkg::ADDR_STATUS, 32'h1, OK);
    results;
  end
endmodule

// ==== tio_far_model.sv ====
// Far-side model: trigger source, underflow source and output load
`timescale 1ns/1ps
module tio_far_model
(
  input  wire logic clk,     // System clock
  input  wire logic trigCmd, // Requested pin level
  input  wire logic ufOn,    // Underflow pulses on
  input  wire logic outPin,  // Waveform level
  input  wire logic outEn,   // Waveform enable
  output logic      trigPin, // Trigger pin
  output logic      ufPulse, // Underflow pulse
  output logic      loadLvl  // Level seen at load
);
  logic [1:0] ufCnt_q = 2'h0;
  initial
  begin
    trigPin = 1'b0;
    ufPulse = 1'b0;
    loadLvl = 1'b0;
  end
  // Released pin floats, so an undriven load keeps toggling
  always @(posedge clk)
  begin
    trigPin <= trigCmd;
    ufCnt_q <= ufCnt_q + 2'h1;
    ufPulse <= ufOn && (ufCnt_q == 2'h3);
    loadLvl <= outEn ? outPin : ~loadLvl;
  end
endmodule

// ==== tio_pkg.sv ====
// Constants and layouts for the timer I/O and mode configuration block
// What this block does
// - Filter select 00 bypass, else sample phi,/8,/32
// - Edge bit 0 falling, 1 rising trigger
// - Trigger enable bit gates pin start trigger
// - Trigger settings act only in one-shot modes
// - Output switch bit 1 suppresses waveform output
// - Waveform mode level bit inverts all levels
// - One-shot mode level bit selects pulse polarity
// - Wait one-shot level bit sets pulse/wait polarity
// - Gate bit 1 blocks the count source
// - Source field picks phi divisions or underflow
// - Write control 0 loads counter, 1 reload only while counting
// - Mode field selects one of four modes
// - Reserved bits read zero, written zero
// - Counting status reads 1 while counting
// - Running prescaler write with write control 0 loads on source tick
package tio_pkg;
  // ****************************************************
  // Register indices and byte addresses
  // ****************************************************
  localparam logic [31:0] IDX_PIN_IO   = 32'h00FFFFA2;
  localparam logic [31:0] IDX_MODE     = 32'h00FFFFA3;
  localparam logic [31:0] IDX_PRESC    = 32'h00FFFFA4;
  localparam logic [31:0] IDX_STATUS   = 32'h00FFFFA8;
  localparam logic [31:0] ADDR_PIN_IO  = IDX_PIN_IO << 2;
  localparam logic [31:0] ADDR_MODE    = IDX_MODE << 2;
  localparam logic [31:0] ADDR_PRESC   = IDX_PRESC << 2;
  localparam logic [31:0] ADDR_STATUS  = IDX_STATUS << 2;
  // ****************************************************
  // Field positions, masks and reset values
  // ****************************************************
  localparam int          FILT_LSB     = 4;
  localparam int          EDGE_BIT     = 3;
  localparam int          TRIGEN_BIT   = 2;
  localparam int          OUTDIS_BIT   = 1;
  localparam int          LEVEL_BIT    = 0;
  localparam int          GATE_BIT     = 7;
  localparam int          SRC_LSB      = 4;
  localparam int          WRC_BIT      = 3;
  localparam int          MODE_LSB     = 0;
  localparam logic [7:0]  PIN_IO_MASK  = 8'h3F;
  localparam logic [7:0]  MODE_MASK    = 8'hFB;
  localparam logic [7:0]  PIN_IO_RST   = 8'h00;
  localparam logic [7:0]  MODE_RST     = 8'h00;
  localparam logic [7:0]  PRESC_RST    = 8'hFF;
  // ****************************************************
  // Field encodings
  // ****************************************************
  localparam logic [1:0]  MODE_TIMER   = 2'h0;
  localparam logic [1:0]  MODE_WAVE    = 2'h1;
  localparam logic [1:0]  MODE_ONESHOT = 2'h2;
  localparam logic [1:0]  MODE_WAIT    = 2'h3;
  localparam logic [1:0]  FILT_OFF     = 2'h0;
  localparam logic [1:0]  FILT_PHI     = 2'h1;
  localparam logic [1:0]  FILT_DIV8    = 2'h2;
  localparam logic [1:0]  FILT_DIV32   = 2'h3;
  localparam logic [2:0]  SRC_PHI      = 3'h0;
  localparam logic [2:0]  SRC_DIV8     = 3'h1;
  localparam logic [2:0]  SRC_UNDER    = 3'h2;
  localparam logic [2:0]  SRC_DIV2     = 3'h3;
  localparam logic [2:0]  SRC_DIV4     = 3'h4;
  localparam logic [2:0]  SRC_DIV32    = 3'h5;
  localparam logic [2:0]  SRC_DIV64    = 3'h6;
  localparam logic [2:0]  SRC_DIV128   = 3'h7;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // ****************************************************
  // Divider ticks and filter depth
  // ****************************************************
  localparam int          DIV_W        = 7;
  localparam int          TICK_N       = 8;
  localparam int          TICK_PHI     = 0;
  localparam int          TICK_DIV2    = 1;
  localparam int          TICK_DIV4    = 2;
  localparam int          TICK_DIV8    = 3;
  localparam int          TICK_DIV32   = 5;
  localparam int          TICK_DIV64   = 6;
  localparam int          TICK_DIV128  = 7;
  localparam logic [1:0]  FILT_MATCH   = 2'h2;
endpackage

// ==== tio_prescale_div.sv ====
// Free-running divider producing phi/2^k one-cycle tick enables
`timescale 1ns/1ps
module tio_prescale_div
(
  input  wire logic clk,        // System clock phi
  input  wire logic sys_rst,    // Synchronous reset, high
  tio_tick_if.src   ticks       // Tick enables out
);
  typedef struct packed
  {
    logic [tio_pkg::DIV_W-1:0] cnt;
  } tio_div_t;

  tio_div_t q;
  tio_div_t d;

  always_comb
  begin
    d = q;
    d.cnt = q.cnt + 7'h01;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end

  assign ticks.tick[0] = 1'b1;
  for (genvar k = 1; k < tio_pkg::TICK_N; k++)
  begin : g_tick
    assign ticks.tick[k] = &q.cnt[k-1:0];
  end
endmodule

// ==== tio_tick_if.sv ====
// Divided-clock tick enables shared between divider and consumers
`timescale 1ns/1ps
interface tio_tick_if;
  logic [tio_pkg::TICK_N-1:0] tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

// ==== tio_timer_cfg.sv ====
// Timer I/O and mode configuration registers with AXI4-Lite slave
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module tio_timer_cfg
(
  input  wire logic        clk,             // System clock phi, 250 MHz
  input  wire logic        sys_rst,         // Synchronous reset, high
  input  wire logic [31:0] s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [31:0] s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  input  wire logic        extTriggerPin,   // External trigger pin
  input  wire logic        raUnderflow,     // Other timer underflow pulse
  input  wire logic        countingStatus,  // Counter is counting
  input  wire logic        inPrimary,       // Counter in primary period
  input  wire logic        pulseOn,         // One-shot pulse phase
  output logic [1:0]       opModeSel,       // Operating mode
  output logic             reloadWriteCtrl, // Reload-only write control
  output logic             countSrcTick,    // Gated count source tick
  output logic [7:0]       prescReloadVal,  // Prescaler reload value
  output logic             prescCntLoad,    // Load prescaler counter pulse
  output logic             trigFire,        // One-shot start pulse
  output logic             waveOutPin,      // Waveform output level
  output logic             waveOutPinEn     // Waveform output enable
);
  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed
  {
    logic        awFree;
    logic [31:0] awAddr;
    logic        wFree;
    logic [7:0]  wData;
    logic        wLane0;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arFree;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [7:0]  pinIo;
    logic [7:0]  modeCtl;
    logic [7:0]  prescReload;
    logic        loadPend;
    logic        prescLoad;
    logic        srcTick;
    logic        trigPrev;
    logic        trigFire;
    logic        waveOut;
    logic        waveEn;
  } tio_state_t;

  tio_state_t q;
  tio_state_t d;
  logic       wrPresc;
  logic       trigLevel;
  logic       filtBypass;
  logic       filtSample;
  logic       srcSel;
  logic       edgeHit;
  logic       waveBase;
  logic [1:0] modeNow;

  tio_tick_if ticks ();

  // ****************************************************
  // Divider and trigger filter
  // ****************************************************
  tio_prescale_div u_div
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ticks   (ticks)
  );

  tio_trig_filter u_filt
  (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pinRaw   (extTriggerPin),
    .bypass   (filtBypass),
    .sampleEn (filtSample),
    .level    (trigLevel)
  );

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb
  begin
    d = q;
    wrPresc = 1'b0;
    d.prescLoad = 1'b0;
    modeNow = q.modeCtl[tio_pkg::MODE_LSB +: 2];
    // Write address and data taken in either order
    if (s_axi_awvalid && q.awFree)
    begin
      d.awAddr = s_axi_awaddr;
      d.awFree = 1'b0;
    end
    if (s_axi_wvalid && q.wFree)
    begin
      d.wData = s_axi_wdata[7:0];
      d.wLane0 = s_axi_wstrb[0];
      d.wFree = 1'b0;
    end
    if (q.bValid && s_axi_bready)
      d.bValid = 1'b0;
    if (!q.awFree && !q.wFree && !q.bValid)
    begin
      d.awFree = 1'b1;
      d.wFree = 1'b1;
      d.bValid = 1'b1;
      d.bResp = tio_pkg::RESP_OKAY;
      if (q.awAddr == tio_pkg::ADDR_PIN_IO)
      begin
        if (q.wLane0)
          d.pinIo = q.wData & tio_pkg::PIN_IO_MASK;
      end
      else if (q.awAddr == tio_pkg::ADDR_MODE)
      begin
        if (q.wLane0)
          d.modeCtl = q.wData & tio_pkg::MODE_MASK;
      end
      else if (q.awAddr == tio_pkg::ADDR_PRESC)
        wrPresc = q.wLane0;
      else if (q.awAddr != tio_pkg::ADDR_STATUS)
        d.bResp = tio_pkg::RESP_SLVERR;
    end
    // Prescaler reload and counter load timing
    if (wrPresc)
    begin
      d.prescReload = q.wData;
      if (!countingStatus)
      begin
        d.prescLoad = 1'b1;
        d.loadPend = 1'b0;
      end
      else if (!q.modeCtl[tio_pkg::WRC_BIT])
        d.loadPend = 1'b1;
    end
    else if (q.loadPend && q.srcTick)
    begin
      d.prescLoad = 1'b1;
      d.loadPend = 1'b0;
    end
    // Read channel
    if (q.rValid && s_axi_rready)
    begin
      d.rValid = 1'b0;
      d.arFree = 1'b1;
    end
    if (s_axi_arvalid && q.arFree)
    begin
      d.arFree = 1'b0;
      d.rValid = 1'b1;
      d.rResp = tio_pkg::RESP_OKAY;
      d.rData = 32'h00000000;
      if (s_axi_araddr == tio_pkg::ADDR_PIN_IO)
        d.rData[7:0] = q.pinIo & tio_pkg::PIN_IO_MASK;
      else if (s_axi_araddr == tio_pkg::ADDR_MODE)
        d.rData[7:0] = q.modeCtl & tio_pkg::MODE_MASK;
      else if (s_axi_araddr == tio_pkg::ADDR_PRESC)
        d.rData[7:0] = q.prescReload;
      else if (s_axi_araddr == tio_pkg::ADDR_STATUS)
        d.rData[1:0] = {q.loadPend, countingStatus};
      else
        d.rResp = tio_pkg::RESP_SLVERR;
    end
    // Count source selection and cutoff
    case (q.modeCtl[tio_pkg::SRC_LSB +: 3])
      tio_pkg::SRC_PHI:    srcSel = ticks.tick[tio_pkg::TICK_PHI];
      tio_pkg::SRC_DIV8:   srcSel = ticks.tick[tio_pkg::TICK_DIV8];
      tio_pkg::SRC_UNDER:  srcSel = raUnderflow;
      tio_pkg::SRC_DIV2:   srcSel = ticks.tick[tio_pkg::TICK_DIV2];
      tio_pkg::SRC_DIV4:   srcSel = ticks.tick[tio_pkg::TICK_DIV4];
      tio_pkg::SRC_DIV32:  srcSel = ticks.tick[tio_pkg::TICK_DIV32];
      tio_pkg::SRC_DIV64:  srcSel = ticks.tick[tio_pkg::TICK_DIV64];
      default:             srcSel = ticks.tick[tio_pkg::TICK_DIV128];
    endcase
    d.srcTick = srcSel && !q.modeCtl[tio_pkg::GATE_BIT];
    // Trigger edge detection
    d.trigPrev = trigLevel;
    if (q.pinIo[tio_pkg::EDGE_BIT])
      edgeHit = trigLevel && !q.trigPrev;
    else
      edgeHit = !trigLevel && q.trigPrev;
    d.trigFire = edgeHit && q.pinIo[tio_pkg::TRIGEN_BIT]
                 && (modeNow == tio_pkg::MODE_ONESHOT || modeNow == tio_pkg::MODE_WAIT);
    // Waveform output level
    case (modeNow)
      tio_pkg::MODE_WAVE:    waveBase = countingStatus && inPrimary;
      tio_pkg::MODE_ONESHOT: waveBase = pulseOn;
      tio_pkg::MODE_WAIT:    waveBase = pulseOn;
      default:               waveBase = 1'b0;
    endcase
    if (q.pinIo[tio_pkg::OUTDIS_BIT])
    begin
      d.waveOut = 1'b0;
      d.waveEn = 1'b0;
    end
    else
    begin
      d.waveOut = waveBase ^ q.pinIo[tio_pkg::LEVEL_BIT];
      d.waveEn = 1'b1;
    end
  end

  // ****************************************************
  // Filter control
  // ****************************************************
  always_comb
  begin
    filtBypass = q.pinIo[tio_pkg::FILT_LSB +: 2] == tio_pkg::FILT_OFF;
    case (q.pinIo[tio_pkg::FILT_LSB +: 2])
      tio_pkg::FILT_PHI:   filtSample = ticks.tick[tio_pkg::TICK_PHI];
      tio_pkg::FILT_DIV8:  filtSample = ticks.tick[tio_pkg::TICK_DIV8];
      tio_pkg::FILT_DIV32: filtSample = ticks.tick[tio_pkg::TICK_DIV32];
      default:             filtSample = 1'b0;
    endcase
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.awFree <= 1'b1;
      q.wFree <= 1'b1;
      q.arFree <= 1'b1;
      q.pinIo <= tio_pkg::PIN_IO_RST;
      q.modeCtl <= tio_pkg::MODE_RST;
      q.prescReload <= tio_pkg::PRESC_RST;
    end
    else
      q <= d;
  end

  assign s_axi_awready   = q.awFree;
  assign s_axi_wready    = q.wFree;
  assign s_axi_bresp     = q.bResp;
  assign s_axi_bvalid    = q.bValid;
  assign s_axi_arready   = q.arFree;
  assign s_axi_rdata     = q.rData;
  assign s_axi_rresp     = q.rResp;
  assign s_axi_rvalid    = q.rValid;
  assign opModeSel       = q.modeCtl[tio_pkg::MODE_LSB +: 2];
  assign reloadWriteCtrl = q.modeCtl[tio_pkg::WRC_BIT];
  assign countSrcTick    = q.srcTick;
  assign prescReloadVal  = q.prescReload;
  assign prescCntLoad    = q.prescLoad;
  assign trigFire        = q.trigFire;
  assign waveOutPin      = q.waveOut;
  assign waveOutPinEn    = q.waveEn;

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_out_disable;
    q.pinIo[tio_pkg::OUTDIS_BIT] |=> !waveOutPinEn && !waveOutPin;
  endproperty
  a_out_disable: assert property (p_out_disable) else $error("output not suppressed");

  property p_trig_mode;
    trigFire |-> $past(q.pinIo[tio_pkg::TRIGEN_BIT]) && $past(q.modeCtl[1]);
  endproperty
  a_trig_mode: assert property (p_trig_mode) else $error("trigger outside one-shot");

  property p_trig_edge;
    trigFire |-> $past(trigLevel) == $past(q.pinIo[tio_pkg::EDGE_BIT])
                 && $past(trigLevel, 2) != $past(q.pinIo[tio_pkg::EDGE_BIT]);
  endproperty
  a_trig_edge: assert property (p_trig_edge) else $error("trigger on wrong edge");

  property p_gate;
    q.modeCtl[tio_pkg::GATE_BIT] |=> !countSrcTick;
  endproperty
  a_gate: assert property (p_gate) else $error("source passes while cut off");

  property p_src_phi;
    // Skip the edge on which reset is let go
    !sys_rst && !q.modeCtl[tio_pkg::GATE_BIT] && q.modeCtl[6:4] == tio_pkg::SRC_PHI
      |=> countSrcTick;
  endproperty
  a_src_phi: assert property (p_src_phi) else $error("phi source missing ticks");

  property p_wave_stop;
    opModeSel == tio_pkg::MODE_WAVE && !countingStatus && !q.pinIo[tio_pkg::OUTDIS_BIT]
      |=> waveOutPin == $past(q.pinIo[tio_pkg::LEVEL_BIT]);
  endproperty
  a_wave_stop: assert property (p_wave_stop) else $error("stopped level wrong");

  property p_shot_idle;
    opModeSel[1] && !pulseOn && !q.pinIo[tio_pkg::OUTDIS_BIT]
      |=> waveOutPin == $past(q.pinIo[tio_pkg::LEVEL_BIT]);
  endproperty
  a_shot_idle: assert property (p_shot_idle) else $error("one-shot idle level wrong");

  property p_reserved;
    q.pinIo[7:6] == 2'b00 && q.modeCtl[2] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_wrc_reload;
    wrPresc && countingStatus && reloadWriteCtrl && !q.loadPend |=> !prescCntLoad [*2];
  endproperty
  a_wrc_reload: assert property (p_wrc_reload) else $error("counter loaded with write control 1");

  property p_stop_load;
    wrPresc && !countingStatus |=> prescCntLoad && prescReloadVal == $past(q.wData);
  endproperty
  a_stop_load: assert property (p_stop_load) else $error("stopped write did not load");

  property p_pend_load;
    q.loadPend && q.srcTick && !wrPresc |=> prescCntLoad && !q.loadPend;
  endproperty
  a_pend_load: assert property (p_pend_load) else $error("pending load not moved");

  c_trig: cover property (trigFire);
  c_pend: cover property (q.loadPend ##[1:200] prescCntLoad);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == tio_pkg::RESP_SLVERR);
endmodule

// ==== tio_trig_filter.sv ====
// Trigger pin synchroniser and sampled noise filter
`timescale 1ns/1ps
module tio_trig_filter
(
  input  wire logic clk,        // System clock phi
  input  wire logic sys_rst,    // Synchronous reset, high
  input  wire logic pinRaw,     // Asynchronous trigger pin
  input  wire logic bypass,     // No filtering
  input  wire logic sampleEn,   // Filter sampling tick
  output logic      level       // Cleaned trigger level
);
  typedef struct packed
  {
    logic       s1;
    logic       s2;
    logic       last;
    logic [1:0] cnt;
    logic       out;
  } tio_filt_t;

  tio_filt_t q;
  tio_filt_t d;

  always_comb
  begin
    d = q;
    d.s1 = pinRaw;
    d.s2 = q.s1;
    if (bypass)
    begin
      d.out = q.s2;
      d.last = q.s2;
      d.cnt = 2'h0;
    end
    else if (sampleEn)
    begin
      if (q.s2 != q.last)
      begin
        d.last = q.s2;
        d.cnt = 2'h0;
      end
      else if (q.cnt == tio_pkg::FILT_MATCH)
        d.out = q.s2;
      else
        d.cnt = q.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end

  assign level = q.out;

  property p_bypass;
    @(posedge clk) disable iff (sys_rst)
    bypass && $past(bypass) |-> q.out == $past(q.s2);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass does not follow pin");
endmodule
